/* File: rtl/serial_pin_ctrl.sv */
// Dual serial controller: host bus, daisy chain and channel pins
// Operation
// R01 - Multiplexed bus latches register address at address strobe rise.
// R02 - Active-low select latched with address; transaction needs it asserted.
// R03 - Host holds high select for whole transaction; otherwise ignored.
// R04 - Both strobes low means reset; data strobe times read or write.
// R05 - Channel select high picks A; data/control high picks data.
// R06 - Host holds chip enable low for whole separate-bus transaction.
// R07 - Data lines driven only during read; vector only when top priority.
// R08 - Read and write strobes together mean reset, not access.
// R09 - Clear-to-send gates transmitter in auto mode; both edges reported.
// R10 - Carrier detect gates receiver in auto mode; both edges reported.
// R11 - Terminal-ready output follows its bit, or acts as DMA request.
// R12 - Chain enable input high means no higher-priority request or service.
// R13 - Chain output high only when input high, idle, not acknowledging.
// R14 - Acknowledge latched; read strobe then drives vector if chain high.
// R15 - Open-drain interrupt output pulled low while a request is pending.
// R16 - Master clock unrelated in phase, at least 90 percent CPU rate.
// R17 - Send-request pin follows its bit; auto async release waits empty.
// R18 - Channel clock pin feeds chosen clock; receive rate 1/16/32/64.
// R19 - Async mode: sync pin input, transitions only update hunt status.
// R20 - External sync: low two clocks after sync; assembly starts.
// R21 - Internal sync: unlatched output pulse per recognition; flags in SDLC.
// R22 - Wait/request pin: open-drain wait or driven request; reset wait.
// R23 - Host strobes and selects pass two flip-flops before use.
`timescale 1ns/10ps
`include "serial_ctrl_defs.svh"
module serial_pin_ctrl (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic bus_mux_mode,
	// Shared data pins
	input wire logic [7:0] mux_addr_data_in,
	output logic [7:0] mux_addr_data_out,
	output logic mux_addr_data_oe,
	// Multiplexed bus timing
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	input wire logic chip_sel_latched_n,
	input wire logic chip_sel_level,
	input wire logic read_not_write,
	// Separate bus timing
	input wire logic chan_sel_a,
	input wire logic data_not_ctrl,
	input wire logic chip_en_n,
	input wire logic rd_n,
	input wire logic wr_n,
	// Interrupt chain
	input wire logic chain_enable_in,
	output logic chain_enable_out,
	input wire logic irq_ack_n,
	output logic irq_n_out,
	output logic irq_n_oe,
	input wire logic irq_pending,
	input wire logic [7:0] irq_vector,
	input wire logic irq_done,
	output logic irq_in_service,
	// User side of register traffic
	output logic wr_word_valid,
	input wire logic wr_word_ready,
	output logic [15:0] wr_word_data,
	output logic rd_strobe,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic bus_reset,
	// Modem control, per channel (bit 1 = A)
	input wire logic [1:0] cts_n,
	input wire logic [1:0] dcd_n,
	input wire logic [1:0] auto_enable,
	output logic [1:0] tx_enable,
	output logic [1:0] rx_enable,
	output logic [1:0] modem_change,
	input wire logic [1:0] dtr_bit,
	input wire logic [1:0] dma_mode,
	input wire logic [1:0] dma_req,
	output logic [1:0] dtr_req_n,
	input wire logic [1:0] rts_bit,
	input wire logic [1:0] async_mode,
	input wire logic [1:0] tx_empty,
	output logic [1:0] rts_n,
	// Sync pins, per channel
	input wire logic [3:0] sync_mode,
	input wire logic [1:0] sync_in,
	output logic [1:0] sync_out,
	output logic [1:0] sync_oe,
	input wire logic [1:0] sync_recog,
	output logic [1:0] sync_hunt,
	output logic [1:0] assembly_start,
	// Clock pins, per channel
	input wire logic [1:0] rxtx_clk_in,
	input wire logic [3:0] clk_src_sel,
	input wire logic [3:0] clk_mult,
	output logic [1:0] rx_clk_tick,
	output logic [1:0] tx_clk_tick,
	output logic [1:0] brg_clk_tick,
	output logic [1:0] pll_clk_tick,
	output logic [1:0] rx_bit_tick,
	// Wait/request pins, per channel
	input wire logic [1:0] req_mode,
	output logic [1:0] wait_req_out,
	output logic [1:0] wait_req_oe
);
	// ==========================================================
	// Input synchronisers
	logic [`SYNC_W-1:0] sync_raw, meta_r, stab_r;
	assign sync_raw = {mux_addr_data_in, addr_strobe_n, data_strobe_n,
		chip_sel_latched_n, chip_sel_level, read_not_write, chan_sel_a,
		data_not_ctrl, chip_en_n, rd_n, wr_n, chain_enable_in, irq_ack_n,
		cts_n, dcd_n, sync_in, rxtx_clk_in};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '1;
			stab_r <= '1;
		end else if (ce) begin
			meta_r <= sync_raw; // [R23]
			stab_r <= meta_r;
		end
	end

	logic [7:0] s_ad;
	logic s_astb, s_dstb, s_lsel, s_hsel, s_rw, s_ab, s_dc, s_cen, s_rd, s_wr;
	logic s_chn, s_ack;
	logic [1:0] s_cts, s_dcd, s_sync, s_rxc;
	assign {s_ad, s_astb, s_dstb, s_lsel, s_hsel, s_rw, s_ab, s_dc, s_cen,
		s_rd, s_wr, s_chn, s_ack, s_cts, s_dcd, s_sync, s_rxc} = stab_r;

	// ==========================================================
	// Host bus decode
	serial_ctrl_pkg::bus_state_t state_r, state_nxt;
	logic [7:0] addr_r, addr_nxt, dout_r, dout_nxt;
	logic lsel_r, lsel_nxt, ack_r, ack_nxt, astb_prev_r, astb_prev_nxt;
	logic svc_r, svc_nxt, push_r, push_nxt, rds_r, rds_nxt;
	logic brst_r, brst_nxt, vec_r, vec_nxt;
	serial_ctrl_pkg::word_t word_r, word_nxt;
	logic rst_cmd, sel, rd_act, wr_act, fifo_ready;

	// Both strobe pairs low at once is a reset, never an access
	assign rst_cmd = bus_mux_mode ? (!s_astb && !s_dstb) // [R04]
		: (!s_rd && !s_wr); // [R08]
	assign sel = bus_mux_mode ? (!lsel_r && s_hsel) // [R02] [R03]
		: !s_cen; // [R06]
	assign rd_act = bus_mux_mode ? (!s_dstb && s_rw) : !s_rd; // [R04]
	assign wr_act = bus_mux_mode ? (!s_dstb && !s_rw) : !s_wr;

	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		lsel_nxt = lsel_r;
		ack_nxt = ack_r;
		astb_prev_nxt = s_astb;
		dout_nxt = dout_r;
		svc_nxt = svc_r;
		push_nxt = push_r && !fifo_ready;
		word_nxt = word_r;
		rds_nxt = 1'b0;
		brst_nxt = 1'b0;
		vec_nxt = vec_r;
		if (bus_mux_mode) begin
			if (s_astb && !astb_prev_r) begin
				addr_nxt = s_ad; // [R01]
				lsel_nxt = s_lsel; // [R02]
				ack_nxt = !s_ack; // [R14]
			end
		end else begin
			ack_nxt = !s_ack; // [R14]
			addr_nxt = {6'h00, s_ab, s_dc}; // [R05]
		end
		if (irq_done)
			svc_nxt = 1'b0;
		case (state_r)
			serial_ctrl_pkg::BUS_IDLE: begin
				if (rst_cmd) begin
					state_nxt = serial_ctrl_pkg::BUS_RESET;
					brst_nxt = 1'b1;
				end else if (ack_r && rd_act) begin
					// Chain low means a higher device owns the cycle
					if (s_chn && irq_pending) begin // [R07] [R12] [R14]
						state_nxt = serial_ctrl_pkg::BUS_READ;
						vec_nxt = 1'b1;
						dout_nxt = irq_vector;
						svc_nxt = 1'b1;
					end
				end else if (sel && rd_act) begin
					state_nxt = serial_ctrl_pkg::BUS_READ;
					vec_nxt = 1'b0;
					rds_nxt = 1'b1;
				end else if (sel && wr_act && !push_r) begin
					state_nxt = serial_ctrl_pkg::BUS_WRITE;
				end
			end
			serial_ctrl_pkg::BUS_READ: begin
				if (!vec_r)
					dout_nxt = rd_data;
				if (!rd_act)
					state_nxt = serial_ctrl_pkg::BUS_IDLE;
			end
			serial_ctrl_pkg::BUS_WRITE: begin
				// Data taken at strobe release, when the host has it settled
				if (!wr_act || rst_cmd) begin
					state_nxt = serial_ctrl_pkg::BUS_IDLE;
					if (!rst_cmd && sel) begin
						push_nxt = 1'b1;
						word_nxt = {addr_r, s_ad};
					end
				end
			end
			serial_ctrl_pkg::BUS_RESET: begin
				if (!rst_cmd)
					state_nxt = serial_ctrl_pkg::BUS_IDLE;
			end
			default: state_nxt = serial_ctrl_pkg::BUS_IDLE;
		endcase
		if (brst_nxt) begin
			svc_nxt = 1'b0;
			push_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= serial_ctrl_pkg::BUS_IDLE;
			addr_r <= 8'h00;
			lsel_r <= 1'b1;
			ack_r <= 1'b0;
			astb_prev_r <= 1'b1;
			dout_r <= 8'h00;
			svc_r <= 1'b0;
			push_r <= 1'b0;
			word_r <= 16'h0000;
			rds_r <= 1'b0;
			brst_r <= 1'b0;
			vec_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			lsel_r <= lsel_nxt;
			ack_r <= ack_nxt;
			astb_prev_r <= astb_prev_nxt;
			dout_r <= dout_nxt;
			svc_r <= svc_nxt;
			push_r <= push_nxt;
			word_r <= word_nxt;
			rds_r <= rds_nxt;
			brst_r <= brst_nxt;
			vec_r <= vec_nxt;
		end
	end

	assign mux_addr_data_out = dout_r;
	assign mux_addr_data_oe = (state_r == serial_ctrl_pkg::BUS_READ); // [R07]
	assign rd_strobe = rds_r;
	assign rd_addr = addr_r;
	assign bus_reset = brst_r;
	assign irq_in_service = svc_r;
	assign irq_n_out = 1'b0;
	assign irq_n_oe = irq_pending; // [R15]
	assign chain_enable_out = s_chn && !svc_r // [R13]
		&& !(ack_r && irq_pending);

	// ==========================================================
	// Write buffer
	word_link_if #(.WIDTH(`WORD_W)) wlink ();
	assign wlink.valid = push_r;
	assign wlink.data = word_r;
	assign fifo_ready = wlink.ready;

	word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) wbuf (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_link(wlink),
		.out_valid(wr_word_valid),
		.out_ready(wr_word_ready),
		.out_data(wr_word_data)
	);

	// ==========================================================
	// Channel pins
	function automatic logic [`DIV_W-1:0] mult_limit(input logic [1:0] m);
		case (m)
			`MULT_X16: mult_limit = 6'h0F;
			`MULT_X32: mult_limit = 6'h1F;
			`MULT_X64: mult_limit = 6'h3F;
			default: mult_limit = 6'h00;
		endcase
	endfunction

	logic [1:0] cts_p_r, cts_p_nxt, dcd_p_r, dcd_p_nxt, syn_p_r, syn_p_nxt;
	logic [1:0] rxc_p_r, rxc_p_nxt, rts_r, rts_nxt, dtr_r, dtr_nxt;
	logic [1:0] hunt_r, hunt_nxt, sact_r, sact_nxt, asm_r, asm_nxt;
	logic [1:0] chg_r, chg_nxt, rqm_r, rqm_nxt, bit_r, bit_nxt;
	logic [`DIV_W-1:0] div_r [2];
	logic [`DIV_W-1:0] div_nxt [2];
	logic [1:0] rxc_edge, wait_hold;

	always_comb begin
		for (int c = 0; c < `CH_N; c++) begin
			cts_p_nxt[c] = s_cts[c];
			dcd_p_nxt[c] = s_dcd[c];
			syn_p_nxt[c] = s_sync[c];
			rxc_p_nxt[c] = s_rxc[c];
			rxc_edge[c] = s_rxc[c] && !rxc_p_r[c];
			rqm_nxt[c] = req_mode[c];
			chg_nxt[c] = (s_cts[c] != cts_p_r[c]) // [R09]
				|| (s_dcd[c] != dcd_p_r[c]); // [R10]
			dtr_nxt[c] = dma_mode[c] ? !dma_req[c] : !dtr_bit[c]; // [R11]
			if (rts_bit[c])
				rts_nxt[c] = 1'b0; // [R17]
			else if (async_mode[c] && auto_enable[c])
				rts_nxt[c] = rts_r[c] | tx_empty[c]; // [R17]
			else
				rts_nxt[c] = 1'b1;
			hunt_nxt[c] = hunt_r[c];
			asm_nxt[c] = 1'b0;
			sact_nxt[c] = 1'b0;
			case (sync_mode[2*c +: 2])
				`SYNC_ASYNC: hunt_nxt[c] = s_sync[c]; // [R19]
				`SYNC_EXT: asm_nxt[c] = syn_p_r[c] && !s_sync[c]; // [R20]
				// Held only until the next receive clock rise, never latched
				default: sact_nxt[c] = sync_recog[c] // [R21]
					|| (sact_r[c] && !rxc_edge[c]);
			endcase
			div_nxt[c] = div_r[c];
			bit_nxt[c] = 1'b0;
			if (rxc_edge[c]
				&& clk_src_sel[2*c +: 2] == `SRC_RX) begin
				if (div_r[c] >= mult_limit(clk_mult[2*c +: 2])) begin // [R18]
					div_nxt[c] = '0;
					bit_nxt[c] = 1'b1;
				end else begin
					div_nxt[c] = div_r[c] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cts_p_r <= 2'h3;
			dcd_p_r <= 2'h3;
			syn_p_r <= 2'h3;
			rxc_p_r <= 2'h3;
			rts_r <= 2'h3;
			dtr_r <= 2'h3;
			hunt_r <= 2'h3;
			sact_r <= 2'h0;
			asm_r <= 2'h0;
			chg_r <= 2'h0;
			rqm_r <= {2{`REQ_MODE_RST}}; // [R22]
			bit_r <= 2'h0;
			div_r[0] <= '0;
			div_r[1] <= '0;
		end else if (ce) begin
			cts_p_r <= cts_p_nxt;
			dcd_p_r <= dcd_p_nxt;
			syn_p_r <= syn_p_nxt;
			rxc_p_r <= rxc_p_nxt;
			rts_r <= rts_nxt;
			dtr_r <= dtr_nxt;
			hunt_r <= hunt_nxt;
			sact_r <= sact_nxt;
			asm_r <= asm_nxt;
			chg_r <= chg_nxt;
			rqm_r <= rqm_nxt;
			bit_r <= bit_nxt;
			div_r[0] <= div_nxt[0];
			div_r[1] <= div_nxt[1];
		end
	end

	// Auto enables follow the synchronised pin levels
	assign tx_enable = ~auto_enable | ~s_cts; // [R09]
	assign rx_enable = ~auto_enable | ~s_dcd; // [R10]
	assign modem_change = chg_r;
	assign dtr_req_n = dtr_r;
	assign rts_n = rts_r;
	assign sync_hunt = hunt_r;
	assign assembly_start = asm_r;
	assign sync_out = ~sact_r;
	assign rx_bit_tick = bit_r;

	// Wait stalls a host write while the buffer has not yet taken the previous word
	assign wait_hold = {2{push_r && sel && wr_act}};

	generate
		for (genvar c = 0; c < `CH_N; c++) begin : g_ch
			assign sync_oe[c] = sync_mode[2*c+1]; // [R21]
			assign rx_clk_tick[c] = rxc_edge[c]
				&& clk_src_sel[2*c +: 2] == `SRC_RX; // [R18]
			assign tx_clk_tick[c] = rxc_edge[c]
				&& clk_src_sel[2*c +: 2] == `SRC_TX;
			assign brg_clk_tick[c] = rxc_edge[c]
				&& clk_src_sel[2*c +: 2] == `SRC_BRG;
			assign pll_clk_tick[c] = rxc_edge[c]
				&& clk_src_sel[2*c +: 2] == `SRC_PLL;
			assign wait_req_out[c] = rqm_r[c] ? !dma_req[c] : 1'b0; // [R22]
			assign wait_req_oe[c] = rqm_r[c] ? 1'b1 : wait_hold[c];
		end
	endgenerate
endmodule // serial_pin_ctrl

/* File: rtl/serial_ctrl_defs.svh */
// Constants for the dual serial controller pin interface
`ifndef SERIAL_CTRL_DEFS_SVH
`define SERIAL_CTRL_DEFS_SVH
`define DATA_W 8
`define WORD_W 16
`define FIFO_DEPTH 8
`define CH_N 2
`define SYNC_W 28
`define REQ_MODE_RST 1'b0
`define SRC_RX 2'h0
`define SRC_TX 2'h1
`define SRC_BRG 2'h2
`define SRC_PLL 2'h3
`define MULT_X1 2'h0
`define MULT_X16 2'h1
`define MULT_X32 2'h2
`define MULT_X64 2'h3
`define SYNC_ASYNC 2'h0
`define SYNC_EXT 2'h1
`define SYNC_INT 2'h2
`define SYNC_SDLC 2'h3
`define DIV_W 6
`endif

/* File: rtl/serial_ctrl_pkg.sv */
// Types shared by the serial controller modules
package serial_ctrl_pkg;
	typedef enum logic [3:0] {
		BUS_IDLE = 4'h1,
		BUS_READ = 4'h2,
		BUS_WRITE = 4'h4,
		BUS_RESET = 4'h8
	} bus_state_t;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
endpackage

/* File: rtl/word_link_if.sv */
// Valid/ready word link between the bus front end and its FIFO
`timescale 1ns/10ps
interface word_link_if #(parameter int WIDTH = 16);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // word_link_if

/* File: rtl/word_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Fill side
	word_link_if.snk in_link,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [CW-1:0] count_r, count_nxt;
	logic push, pop;

	// ==========================================================
	// Flags and pointers
	assign in_link.ready = (count_r != FULL);
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_ptr_r];
	assign push = in_link.valid && in_link.ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		if (push)
			wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
		if (pop)
			rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else if (ce) begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end

	// ==========================================================
	// Storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (ce && push)
			mem_r[wr_ptr_r] <= in_link.data;
	end
endmodule // word_fifo

/* File: test/serial_pin_ctrl_asserts.sv */
// Concurrent checks on the serial controller pins
`timescale 1ns/10ps
module serial_pin_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host bus
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic mux_addr_data_oe,
	input wire logic bus_reset,
	// Interrupt chain
	input wire logic irq_pending,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire logic irq_in_service,
	input wire logic chain_enable_out,
	// Channel pins
	input wire logic [1:0] cts_n,
	input wire logic [1:0] dcd_n,
	input wire logic [1:0] auto_enable,
	input wire logic [1:0] tx_enable,
	input wire logic [1:0] rx_enable,
	input wire logic [1:0] dtr_bit,
	input wire logic [1:0] dma_mode,
	input wire logic [1:0] dma_req,
	input wire logic [1:0] dtr_req_n,
	input wire logic [1:0] rts_bit,
	input wire logic [1:0] async_mode,
	input wire logic [1:0] rts_n,
	input wire logic [3:0] sync_mode,
	input wire logic [1:0] sync_oe,
	input wire logic [1:0] wait_req_out
);
	logic direct0;
	assign direct0 = !async_mode[0] || !auto_enable[0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========
	// Checks
	chk_irq_drive: assert property (
		irq_n_oe == irq_pending && !irq_n_out)
		else $error("interrupt pin drive wrong");
	chk_chain_block: assert property (
		irq_in_service |-> !chain_enable_out)
		else $error("chain passed while in service");
	chk_read_drive: assert property (
		$rose(mux_addr_data_oe) |-> $past(!rd_n, 3) ||
		$past(!data_strobe_n && read_not_write, 3))
		else $error("data pins driven without read");
	chk_reset_cause: assert property (
		bus_reset |-> $past(!addr_strobe_n && !data_strobe_n, 3) ||
		$past(!rd_n && !wr_n, 3))
		else $error("bus reset without coincidence");
	chk_tx_gate: assert property (
		auto_enable[0] && cts_n[0] && $past(cts_n[0]) &&
		$past(cts_n[0], 2) |-> !tx_enable[0])
		else $error("transmitter not gated");
	chk_tx_free: assert property (
		!auto_enable[0] |-> tx_enable[0])
		else $error("transmitter gated without auto");
	chk_rx_gate: assert property (
		auto_enable[0] && dcd_n[0] && $past(dcd_n[0]) &&
		$past(dcd_n[0], 2) |-> !rx_enable[0])
		else $error("receiver not gated");
	chk_dtr_follow: assert property (
		!$past(rst) |-> dtr_req_n[0] == ($past(dma_mode[0]) ?
		!$past(dma_req[0]) : !$past(dtr_bit[0])))
		else $error("ready pin wrong");
	chk_rts_direct: assert property (
		$past(direct0) && $past(direct0, 2) && !$past(rst)
		|-> rts_n[0] == !$past(rts_bit[0]))
		else $error("send request pin wrong");
	chk_sync_dir: assert property (
		sync_oe == {sync_mode[3], sync_mode[1]})
		else $error("sync pin direction wrong");
	chk_wait_reset: assert property (
		$fell(rst) |-> wait_req_out == 2'h0)
		else $error("wait pin not in wait after reset");
endmodule // serial_pin_asserts

bind serial_pin_ctrl serial_pin_asserts serial_pin_asserts_i (.*);

/* File: test/line_peer.sv */
// Far-side model of the serial lines: link clock and sync input
`timescale 1ns/10ps
module line_peer (
	// Link pins
	output logic [1:0] link_clk,
	output logic [1:0] sync_line
);
	// Pulled up, and the clock stands still outside frames
	initial begin
		link_clk = 2'h3;
		sync_line = 2'h3;
	end
	// Own 160 ns timebase, no phase tie to the master clock
	task automatic frame(input int ch, input int edges, input bit ext);
		repeat (edges + (ext ? 2 : 0)) begin
			#80 link_clk[ch] = 1'h0;
			#80 link_clk[ch] = 1'h1;
		end
		// Low two receive clocks after the last sync bit
		if (ext) begin
			sync_line[ch] = 1'h0;
			#480 sync_line[ch] = 1'h1;
		end
	endtask
endmodule // line_peer

/* File: test/serial_pin_ctrl_bench.sv */
// Self-checking bench for the serial controller pin interface
`timescale 1ns/10ps
module serial_pin_ctrl_bench;
	// ==========
	// Signals
	logic clk = 0, rst = 1, ce = 1, bus_mux_mode = 1, read_not_write = 1;
	logic [7:0] mux_addr_data_in, mux_addr_data_out, host_ad = 8'h00;
	logic mux_addr_data_oe, addr_strobe_n = 1, data_strobe_n = 1;
	logic chip_sel_latched_n = 1, chip_sel_level = 0, chan_sel_a = 0;
	logic data_not_ctrl = 0, chip_en_n = 1, rd_n = 1, wr_n = 1;
	logic chain_enable_in = 1, chain_enable_out, irq_ack_n = 1, irq_done = 0;
	logic irq_n_out, irq_n_oe, irq_pending = 0, irq_in_service;
	logic [7:0] irq_vector = 8'h00, rd_addr, rd_data, a, d;
	logic wr_word_valid, wr_word_ready = 1, rd_strobe, bus_reset;
	logic [15:0] wr_word_data, w;
	logic [1:0] cts_n = 3, dcd_n = 3, auto_enable = 0, tx_enable, rx_enable;
	logic [1:0] modem_change, dtr_bit = 0, dma_mode = 0, dma_req = 0;
	logic [1:0] dtr_req_n, rts_bit = 0, async_mode = 0, tx_empty = 0, rts_n;
	logic [3:0] sync_mode = 0, clk_src_sel = 0, clk_mult = 0, sel4;
	logic [1:0] sync_in, sync_out, sync_oe, sync_recog = 0, sync_hunt;
	logic [1:0] assembly_start, rxtx_clk_in, rx_clk_tick, tx_clk_tick;
	logic [1:0] brg_clk_tick, pll_clk_tick, rx_bit_tick, req_mode = 0;
	logic [1:0] wait_req_out, wait_req_oe, peer_sync;
	logic [8:0] got;
	int err_count = 0, num_checks = 0, cyc = 0, seed = 32'h6AEBB562;
	int n_rst = 0, n_bit = 0, n_asm = 0, n_hunt = 0, n_src = 0, n_all = 0;
	int n, k, j, n_rds = 0, n_chg = 0;
	logic [15:0] exp_q[$];
	// Pins shared by two drivers resolve from the enables
	assign mux_addr_data_in = mux_addr_data_oe ? mux_addr_data_out : host_ad;
	assign sync_in = (sync_oe & sync_out) | (~sync_oe & peer_sync);
	assign rd_data = rd_addr ^ 8'hA5;
	assign sel4 = {pll_clk_tick[1], brg_clk_tick[1], tx_clk_tick[1],
		rx_clk_tick[1]};
	always #10 clk = ~clk;
	serial_pin_ctrl serial_pin_ctrl_i (.*);
	line_peer line_peer_i (.link_clk(rxtx_clk_in), .sync_line(peer_sync));
	// ==========
	// Helpers
	function automatic logic [15:0] exp_word(input logic sep,
			input logic [7:0] ad, dd);
		return sep ? {6'h00, ad[1:0], dd} : {ad, dd};
	endfunction
	function automatic int bit_exp(input int i);
		if (i > 3)
			return 0;
		return i == 0 ? 64 : 64 >> (i + 3);
	endfunction
	task automatic check(input string what, input logic [15:0] e, g);
		num_checks++;
		if (e !== g) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Channel B modem pins wander at random; A is left to scenarios
	task automatic tick(input int c);
		repeat (c) begin
			@(posedge clk);
			if (cyc[2:0] == 3'h0)
				{cts_n[0], dcd_n[0], auto_enable[0], dtr_bit[0], dma_mode[0],
					dma_req[0], rts_bit[0], async_mode[0],
					tx_empty[0]} <= 9'($random(seed));
		end
	endtask
	task automatic mux_cyc(input logic [7:0] ad, dd, input logic rd, s0, s1);
		tick(1);
		bus_mux_mode <= 1'h1;
		host_ad <= ad;
		chip_sel_latched_n <= s0;
		chip_sel_level <= s1;
		addr_strobe_n <= 1'h0;
		tick(4);
		addr_strobe_n <= 1'h1;
		tick(4);
		host_ad <= dd;
		read_not_write <= rd;
		data_strobe_n <= 1'h0;
		tick(6);
		got = {mux_addr_data_oe, mux_addr_data_out};
		data_strobe_n <= 1'h1;
		tick(5);
		chip_sel_latched_n <= 1'h1;
		chip_sel_level <= 1'h0;
	endtask
	task automatic sep_cyc(input logic ch, dc, rd, en_n, input logic [7:0] dd);
		tick(1);
		bus_mux_mode <= 1'h0;
		chan_sel_a <= ch;
		data_not_ctrl <= dc;
		chip_en_n <= en_n;
		host_ad <= dd;
		tick(1);
		rd_n <= !rd;
		wr_n <= rd;
		tick(6);
		got = {mux_addr_data_oe, mux_addr_data_out};
		rd_n <= 1'h1;
		wr_n <= 1'h1;
		tick(5);
		chip_en_n <= 1'h1;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		n_rst <= n_rst + bus_reset;
		n_rds <= n_rds + rd_strobe;
		n_chg <= n_chg + modem_change[1];
		n_bit <= n_bit + rx_bit_tick[1];
		n_asm <= n_asm + assembly_start[1];
		n_hunt <= n_hunt + $fell(sync_hunt[1]);
		n_src <= n_src + sel4[clk_src_sel[3:2]];
		n_all <= n_all + sel4[0] + sel4[1] + sel4[2] + sel4[3];
		if (cyc == 40000) begin
			err_count++;
			close_out();
		end
	end
	// ==========
	// Scenarios
	initial begin
		tick(12);
		rst <= 1'h0;
		tick(4);
		check("wait pins", 16'h0, wait_req_out);
		mux_cyc(8'h11, 8'h22, 1'h0, 1'h1, 1'h1);
		mux_cyc(8'h33, 8'h44, 1'h0, 1'h0, 1'h0);
		sep_cyc(1'h1, 1'h1, 1'h0, 1'h1, 8'h55);
		tick(6);
		check("refused write", 16'h0, wr_word_valid);
		// Fill the FIFO while the far side stalls, then drain it
		wr_word_ready <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			a = (i < 4) ? 8'(i) : 8'($random(seed));
			d = 8'($random(seed));
			if (i < 4)
				sep_cyc(a[1], a[0], 1'h0, 1'h0, d);
			else
				mux_cyc(a, d, 1'h0, 1'h0, 1'h1);
			exp_q.push_back(exp_word(i < 4, a, d));
		end
		for (int i = 0; i < 300 && exp_q.size() > 0; i++) begin
			tick(1);
			if (wr_word_valid === 1'h1 && wr_word_ready)
				check("word", exp_q.pop_front(), wr_word_data);
			wr_word_ready <= 1'($random(seed));
		end
		check("words left", 16'h0, 16'(exp_q.size()));
		wr_word_ready <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			a = 8'($random(seed));
			if (i < 4)
				sep_cyc(a[1], a[0], 1'h1, 1'h0, 8'h00);
			else
				mux_cyc(a, 8'h00, 1'h1, 1'h0, 1'h1);
			w = exp_word(i < 4, a, 8'h00);
			check("read data", {1'h1, w[15:8] ^ 8'hA5}, got);
			check("read release", 16'h0, mux_addr_data_oe);
		end
		check("read strobes", 16'h6, 16'(n_rds));
		// Vector read first blocked by the chain, then passed
		irq_vector <= 8'($random(seed));
		irq_pending <= 1'h1;
		irq_ack_n <= 1'h0;
		chain_enable_in <= 1'h0;
		sep_cyc(1'h0, 1'h0, 1'h1, 1'h1, 8'h00);
		check("blocked vector", 16'h0, got[8]);
		check("blocked chain", 16'h0, chain_enable_out);
		chain_enable_in <= 1'h1;
		sep_cyc(1'h0, 1'h0, 1'h1, 1'h1, 8'h00);
		check("vector", {1'h1, irq_vector}, got);
		check("in service", 16'h1, irq_in_service);
		irq_pending <= 1'h0;
		irq_ack_n <= 1'h1;
		irq_done <= 1'h1;
		tick(1);
		irq_done <= 1'h0;
		tick(5);
		check("chain out", 16'h1, chain_enable_out);
		n = n_rst;
		for (int m = 0; m < 2; m++) begin
			tick(1);
			bus_mux_mode <= m[0];
			{addr_strobe_n, data_strobe_n} <= m ? 2'h0 : 2'h3;
			{rd_n, wr_n} <= m ? 2'h3 : 2'h0;
			tick(5);
			{addr_strobe_n, data_strobe_n, rd_n, wr_n} <= 4'hF;
			tick(5);
		end
		check("bus resets", 16'h2, 16'(n_rst - n));
		// Send request: auto release waits for an empty transmitter
		rts_bit[1] <= 1'h1;
		async_mode[1] <= 1'h1;
		auto_enable[1] <= 1'h1;
		tick(3);
		check("rts set", 16'h0, rts_n[1]);
		rts_bit[1] <= 1'h0;
		tick(4);
		check("rts held", 16'h0, rts_n[1]);
		tx_empty[1] <= 1'h1;
		tick(3);
		check("rts released", 16'h1, rts_n[1]);
		// Channel A modem inputs, auto enable still on from above
		n = n_chg;
		cts_n[1] <= 1'h0;
		tick(4);
		check("tx enabled", 16'h1, tx_enable[1]);
		cts_n[1] <= 1'h1;
		dcd_n[1] <= 1'h0;
		tick(4);
		check("tx gated", 16'h0, tx_enable[1]);
		check("rx enabled", 16'h1, rx_enable[1]);
		dcd_n[1] <= 1'h1;
		tick(5);
		check("rx gated", 16'h0, rx_enable[1]);
		check("modem changes", 16'h3, 16'(n_chg - n));
		for (int m = 0; m < 2; m++) begin
			sync_mode[3:2] <= m[1:0];
			tick(3);
			n = n_hunt;
			k = n_asm;
			#3 line_peer_i.frame(1, 4, 1'h1);
			tick(4);
			check("hunt falls", 16'(1 - m), 16'(n_hunt - n));
			check("assembly", 16'(m), 16'(n_asm - k));
		end
		sync_mode[3:2] <= 2'h2;
		tick(3);
		sync_recog <= 2'h2;
		tick(1);
		sync_recog <= 2'h0;
		tick(1);
		check("sync active", 16'h0, sync_in[1]);
		#3 line_peer_i.frame(1, 1, 1'h0);
		tick(4);
		check("sync idle", 16'h1, sync_in[1]);
		for (int i = 0; i < 7; i++) begin
			clk_src_sel[3:2] <= (i < 4) ? 2'h0 : 2'(i - 3);
			clk_mult[3:2] <= (i < 4) ? 2'(i) : 2'h0;
			tick(4);
			n = n_bit;
			k = n_src;
			j = n_all;
			#3 line_peer_i.frame(1, 64, 1'h0);
			tick(8);
			check("source ticks", 16'd64, 16'(n_src - k));
			check("all ticks", 16'd64, 16'(n_all - j));
			check("bit ticks", 16'(bit_exp(i)), 16'(n_bit - n));
		end
		req_mode <= 2'h3;
		dma_req[1] <= 1'h1;
		tick(3);
		check("request drive", 16'h3, wait_req_oe);
		check("request level", 16'h0, wait_req_out[1]);
		tick(10);
		close_out();
	end
endmodule // serial_pin_ctrl_bench
